// *** hdl/csfp_queue.sv ***
/*
 * 64-byte flip-flop queue with fill count.
 * Assumes at most one push and one pop per cycle from the caller.
 */
`timescale 1ns/1ps
module csfp_queue (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Push side
	input wire logic push,
	input wire logic [7:0] push_data,
	// Pop side
	input wire logic pop,
	output logic [7:0] head_data,
	// State
	output logic [6:0] fill_count,
	output logic full,
	output logic empty
);

	logic [7:0] mem_r [csfp_pkg::QUEUE_DEPTH];
	logic [5:0] wr_ptr_r;
	logic [5:0] rd_ptr_r;
	logic [6:0] count_r;
	logic push_ok;
	logic pop_ok;

	// ------------------------------------------------------------
	// Accept logic
	// ------------------------------------------------------------
	assign full = (count_r == csfp_pkg::QUEUE_CNT_FULL);
	assign empty = (count_r == csfp_pkg::QUEUE_CNT_RESET);
	assign push_ok = push && !full; // R20
	assign pop_ok = pop && !empty; // R20
	assign head_data = mem_r[rd_ptr_r];
	assign fill_count = count_r;

	always_ff @(posedge clk) begin
		if (push_ok) begin
			mem_r[wr_ptr_r] <= push_data; // R05
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push_ok) begin
				wr_ptr_r <= wr_ptr_r + 6'h01;
			end
			if (pop_ok) begin
				rd_ptr_r <= rd_ptr_r + 6'h01;
			end
		end
	end

	// Count follows accepted pushes and pops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_r <= csfp_pkg::QUEUE_CNT_RESET; // R18
		end else if (push_ok && !pop_ok) begin
			count_r <= count_r + 7'h01; // R17
		end else if (pop_ok && !push_ok) begin
			count_r <= count_r - 7'h01; // R17
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	count_bound_a: assert property (@(posedge clk) disable iff (!resetn) // R20
		count_r <= csfp_pkg::QUEUE_CNT_FULL)
		else $error("queue count above depth");

	full_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R20
		full && push && !pop |=> count_r == csfp_pkg::QUEUE_CNT_FULL)
		else $error("push into full queue changed count");

endmodule : csfp_queue

// *** hdl/csfp_top.sv ***
/*
 * Command, status and queue register page of the reader front end.
 * Assumes the host register port and the command engine share clk,
 * and that the command engine pulses done when a command finishes.
 */
// Notes on behaviour
// [R01] Command bit 7 reads 1 while port detection runs, 0 once finished.
// [R02] Writing the six-bit code at 01h starts that command.
// [R03] Reading the code returns the command now executing.
// [R04] Command register resets with bits 6 to 0 cleared.
// [R05] Register 02h pushes on write and pops oldest byte on read.
// [R06] The queue carries all data between host and transmit/receive paths; a data path push in the same cycle as a host write is dropped.
// [R07] Status bits 6..4 give modem phase; 000 means idle.
// [R08] Phases 001 frame start, 010 payload, 011 frame end.
// [R09] Phase 100 marks receiver entry and exit steps.
// [R10] Phases 101 guard wait, 110 listening, 111 receiving.
// [R11] Status bit 3 is high when any enabled request is pending.
// [R12] Status bit 2 is the OR of all error flags.
// [R13] Status bit 1 is set when 64 minus count is at most threshold.
// [R14] Status bit 0 is set when count is at most threshold.
// [R15] Main status is read-only, bit 7 reserved, reset value 05h.
// [R16] Register 04h holds the queue byte count in bits 6..0.
// [R17] Each pushed byte adds one, each popped byte subtracts one.
// [R18] Byte count resets to zero.
// [R19] Each request reaches the summary only through its enable bit.
// [R20] Pushes to a full and pops from an empty queue are ignored.
// [R21] Warnings follow the current count and threshold combinationally.
`timescale 1ns/1ps
module csfp_top (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Host register port
	input wire csfp_pkg::csfp_host_req_t host_req,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	// Command engine
	input wire logic host_port_detect_pending,
	input wire logic cmd_done,
	output logic [5:0] cmd_code,
	output logic cmd_start,
	// Transmit and receive data path
	input wire csfp_pkg::csfp_core_req_t core_req,
	output logic [7:0] core_rdata,
	output logic core_rvalid,
	// Status sources
	input wire logic [2:0] modem_phase,
	input wire logic [7:0] error_flag_set,
	input wire logic [5:0] receiver_request,
	input wire logic [5:0] request_enable_mask,
	input wire logic [5:0] alert_threshold,
	// Status mirror
	output logic [7:0] main_status
);

	logic [5:0] cmd_code_r;
	logic cmd_start_r;
	logic detect_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic [7:0] core_rdata_r;
	logic core_rvalid_r;
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic host_wr_cmd;
	logic host_wr_q;
	logic host_rd_q;
	logic q_push;
	logic q_pop;
	logic [7:0] q_push_data;
	logic [7:0] q_head;
	logic [6:0] q_count;
	logic q_full;
	logic q_empty;
	logic core_pop_ok;
	logic near_full_warning;
	logic near_empty_warning;
	logic [7:0] fill_reg;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	// ------------------------------------------------------------
	// Host decode
	// ------------------------------------------------------------
	assign host_wr_cmd = host_req.wr &&
		hit(host_req.addr, csfp_pkg::ADDR_COMMAND_CONTROL);
	assign host_wr_q = host_req.wr &&
		hit(host_req.addr, csfp_pkg::ADDR_QUEUE_DATA_PORT);
	assign host_rd_q = host_req.rd && !host_req.wr &&
		hit(host_req.addr, csfp_pkg::ADDR_QUEUE_DATA_PORT);

	// ------------------------------------------------------------
	// Queue sharing, host first
	// ------------------------------------------------------------
	assign q_push = host_wr_q || core_req.push; // R06
	assign q_push_data = host_wr_q ? host_req.wdata : core_req.data;
	assign core_pop_ok = core_req.pop && !host_rd_q && !q_empty;
	assign q_pop = host_rd_q || core_req.pop; // R06

	csfp_queue u_queue (
		.clk(clk),
		.resetn(resetn),
		.push(q_push),
		.push_data(q_push_data),
		.pop(q_pop),
		.head_data(q_head),
		.fill_count(q_count),
		.full(q_full),
		.empty(q_empty)
	);

	// ------------------------------------------------------------
	// Command register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_code_r <= csfp_pkg::CMD_CODE_RESET; // R04
			cmd_start_r <= 1'b0;
		end else begin
			cmd_start_r <= host_wr_cmd; // R02
			if (host_wr_cmd) begin
				cmd_code_r <= host_req.wdata[5:0]; // R02
			end else if (cmd_done) begin
				cmd_code_r <= csfp_pkg::CMD_CODE_IDLE; // R03
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			detect_r <= csfp_pkg::CMD_DETECT_RESET;
		end else begin
			detect_r <= host_port_detect_pending; // R01
		end
	end

	// ------------------------------------------------------------
	// Status composition
	// ------------------------------------------------------------
	always_comb begin
		near_full_warning = ({1'b0, alert_threshold} >=
			(csfp_pkg::QUEUE_CNT_FULL - q_count)); // R13 R21
		near_empty_warning = (q_count <= {1'b0, alert_threshold}); // R14 R21
		status_nxt = 8'h00; // R15
		status_nxt[6:4] = modem_phase; // R07 R08 R09 R10
		status_nxt[csfp_pkg::STAT_IRQ_BIT] =
			|(receiver_request & request_enable_mask); // R11 R19
		status_nxt[csfp_pkg::STAT_ERR_BIT] = |error_flag_set; // R12
		status_nxt[csfp_pkg::STAT_HI_BIT] = near_full_warning;
		status_nxt[csfp_pkg::STAT_LO_BIT] = near_empty_warning;
	end

	assign fill_reg = {1'b0, q_count}; // R16

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_r <= csfp_pkg::MAIN_STATUS_RESET; // R15
		end else begin
			status_r <= status_nxt;
		end
	end

	// ------------------------------------------------------------
	// Host read path
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= csfp_pkg::UNMAPPED_READ;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= host_req.rd && !host_req.wr;
			if (host_req.rd && !host_req.wr) begin
				unique case (host_req.addr)
					csfp_pkg::ADDR_COMMAND_CONTROL:
						rdata_r <= {detect_r, 1'b0, cmd_code_r}; // R01 R03
					csfp_pkg::ADDR_QUEUE_DATA_PORT:
						rdata_r <= q_empty ? 8'h00 : q_head; // R05
					csfp_pkg::ADDR_MAIN_STATUS:
						rdata_r <= status_nxt; // R15
					csfp_pkg::ADDR_QUEUE_FILL_COUNT:
						rdata_r <= fill_reg; // R16
					default:
						rdata_r <= csfp_pkg::UNMAPPED_READ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Data path read
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_rdata_r <= 8'h00;
			core_rvalid_r <= 1'b0;
		end else begin
			core_rvalid_r <= core_pop_ok; // R06
			if (core_pop_ok) begin
				core_rdata_r <= q_head;
			end
		end
	end

	assign host_rdata = rdata_r;
	assign host_rvalid = rvalid_r;
	assign cmd_code = cmd_code_r;
	assign cmd_start = cmd_start_r;
	assign core_rdata = core_rdata_r;
	assign core_rvalid = core_rvalid_r;
	assign main_status = status_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence host_read_at(logic [7:0] a);
		host_req.rd && !host_req.wr && host_req.addr == a;
	endsequence

	sequence cmd_write_seq;
		host_req.wr && host_req.addr == csfp_pkg::ADDR_COMMAND_CONTROL;
	endsequence

	detect_readback_a: assert property (@(posedge clk) disable iff (!resetn) // R01
		host_read_at(csfp_pkg::ADDR_COMMAND_CONTROL) |=>
		host_rdata[7] == $past(detect_r) && host_rdata[6] == 1'b0)
		else $error("detect bit readback wrong");

	cmd_start_a: assert property (@(posedge clk) disable iff (!resetn) // R02
		cmd_write_seq |=> cmd_start && cmd_code == $past(host_req.wdata[5:0]))
		else $error("command write did not start command");

	cmd_running_a: assert property (@(posedge clk) disable iff (!resetn) // R03
		cmd_write_seq ##1 (!cmd_done && !host_req.wr)
		##1 host_read_at(csfp_pkg::ADDR_COMMAND_CONTROL) |=>
		host_rdata[5:0] == $past(host_req.wdata[5:0], 3))
		else $error("command readback not executing code");

	queue_push_a: assert property (@(posedge clk) disable iff (!resetn) // R17
		host_wr_q && !q_full && !q_pop |=> q_count == $past(q_count) + 7'h01)
		else $error("push did not raise count");

	queue_pop_a: assert property (@(posedge clk) disable iff (!resetn) // R17
		host_rd_q && !q_empty && !q_push |=> q_count == $past(q_count) - 7'h01)
		else $error("pop did not lower count");

	phase_status_a: assert property (@(posedge clk) disable iff (!resetn) // R07
		host_read_at(csfp_pkg::ADDR_MAIN_STATUS) |=>
		host_rdata[6:4] == $past(modem_phase) && !host_rdata[7])
		else $error("modem phase not reported");

	summary_bits_a: assert property (@(posedge clk) disable iff (!resetn) // R11
		$past(resetn) |-> main_status[3:2] == {$past(|(receiver_request &
		request_enable_mask)), $past(|error_flag_set)})
		else $error("request or error summary wrong");

	alert_levels_a: assert property (@(posedge clk) disable iff (!resetn) // R13
		$past(resetn) |-> main_status[1:0] == {$past((7'h40 - q_count) <=
		7'(alert_threshold)), $past(q_count <= 7'(alert_threshold))})
		else $error("alert warnings wrong");

	fill_read_a: assert property (@(posedge clk) disable iff (!resetn) // R16
		host_read_at(csfp_pkg::ADDR_QUEUE_FILL_COUNT) |=>
		host_rdata == {1'b0, $past(q_count)})
		else $error("fill count readback wrong");

endmodule : csfp_top

// *** pkg/csfp_pkg.sv ***
/*
 * Constants and carrier types for the command, status and queue page.
 * Assumes a single system clock and an asynchronous active-low reset.
 */
package csfp_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_COMMAND_CONTROL = 8'h01;
	localparam logic [7:0] ADDR_QUEUE_DATA_PORT = 8'h02;
	localparam logic [7:0] ADDR_MAIN_STATUS = 8'h03;
	localparam logic [7:0] ADDR_QUEUE_FILL_COUNT = 8'h04;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CMD_DETECT_BIT = 7;
	localparam int CMD_CODE_W = 6;
	localparam int STAT_PHASE_LSB = 4;
	localparam int STAT_IRQ_BIT = 3;
	localparam int STAT_ERR_BIT = 2;
	localparam int STAT_HI_BIT = 1;
	localparam int STAT_LO_BIT = 0;
	localparam logic [5:0] CMD_CODE_RESET = 6'h00;
	localparam logic [5:0] CMD_CODE_IDLE = 6'h00;
	localparam logic CMD_DETECT_RESET = 1'b1;
	localparam logic [7:0] MAIN_STATUS_RESET = 8'h05;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ------------------------------------------------------------
	// Queue geometry
	// ------------------------------------------------------------
	localparam int QUEUE_DEPTH = 64;
	localparam int QUEUE_PTR_W = 6;
	localparam int QUEUE_CNT_W = 7;
	localparam logic [6:0] QUEUE_CNT_RESET = 7'h00;
	localparam logic [6:0] QUEUE_CNT_FULL = 7'h40;
	localparam int REQ_SRC_W = 6;

	// ------------------------------------------------------------
	// Modem phase codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PHASE_IDLE = 3'h0,
		PHASE_SEND_FRAME_START = 3'h1,
		PHASE_SEND_PAYLOAD = 3'h2,
		PHASE_SEND_FRAME_END = 3'h3,
		PHASE_RECEIVER_STEP = 3'h4,
		PHASE_RECEIVE_GUARD_WAIT = 3'h5,
		PHASE_RECEIVER_LISTENING = 3'h6,
		PHASE_RECEIVING = 3'h7
	} csfp_phase_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} csfp_host_req_t;

	typedef struct packed {
		logic push;
		logic pop;
		logic [7:0] data;
	} csfp_core_req_t;

endpackage : csfp_pkg

// *** tb/csfp_host_model.sv ***
/*
 * Host processor model for the register page: strobed writes and reads.
 * Assumes the page answers a read with host_rvalid one cycle later.
 */
`timescale 1ns/1ps
module csfp_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output csfp_pkg::csfp_host_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid
);
	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	initial begin
		host_req <= '0;
	end

	// Released address and data show the inverse of the last value
	task automatic idle_bus();
		host_req <= '{1'b0, 1'b0, ~host_req.addr, ~host_req.wdata};
	endtask : idle_bus

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		host_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		idle_bus();
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk);
		host_req <= '{1'b0, 1'b1, a, host_req.wdata};
		@(posedge clk);
		idle_bus();
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge clk);
			if (host_rvalid === 1'b1) begin
				ok = 1'b1;
				d = host_rdata;
			end
		end
	endtask : reg_rd
endmodule : csfp_host_model

// *** tb/test_command_status_fifo_page.sv ***
/*
 * Self-checking bench for the command, status and queue page.
 * Assumes the host model tasks and a 200 MHz clock.
 */
`timescale 1ns/1ps
module test_command_status_fifo_page;
	logic clk;
	logic resetn;
	csfp_pkg::csfp_host_req_t host_req;
	logic [7:0] host_rdata;
	logic host_rvalid;
	logic host_port_detect_pending;
	logic cmd_done;
	logic [5:0] cmd_code;
	logic cmd_start;
	csfp_pkg::csfp_core_req_t core_req;
	logic [7:0] core_rdata;
	logic core_rvalid;
	logic [2:0] modem_phase;
	logic [7:0] error_flag_set;
	logic [5:0] receiver_request;
	logic [5:0] request_enable_mask;
	logic [5:0] alert_threshold;
	logic [7:0] main_status;
	int err_count;
	int n_tests;
	logic [7:0] rd;
	logic ok;
	// Rows: phase, errors, requests, enables, expected status
	logic [30:0] rows [8];

	csfp_top csfp_top_i (.clk(clk), .resetn(resetn), .host_req(host_req),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.host_port_detect_pending(host_port_detect_pending),
		.cmd_done(cmd_done), .cmd_code(cmd_code), .cmd_start(cmd_start),
		.core_req(core_req), .core_rdata(core_rdata),
		.core_rvalid(core_rvalid), .modem_phase(modem_phase),
		.error_flag_set(error_flag_set), .receiver_request(receiver_request),
		.request_enable_mask(request_enable_mask),
		.alert_threshold(alert_threshold), .main_status(main_status));

	csfp_host_model csfp_host_model_i (.clk(clk), .host_req(host_req),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid));

	always #2.5 clk = ~clk;

	// ------------------------------------------------------------
	// Checks and closing
	// ------------------------------------------------------------
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		csfp_host_model_i.reg_rd(a, rd, ok);
		if (ok !== 1'b1) begin
			err_count++;
			$display("MISMATCH t=%0t no answer got=%h exp=%h", $time, rd, exp);
			conclude();
		end else begin
			chk(rd, exp);
		end
	endtask : rd_chk

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		host_port_detect_pending = 1'b1;
		cmd_done = 1'b0;
		core_req = '0;
		modem_phase = 3'h0;
		error_flag_set = 8'h00;
		receiver_request = 6'h00;
		request_enable_mask = 6'h00;
		alert_threshold = 6'h04;
		err_count = 0;
		n_tests = 0;
		rows = '{{3'h0, 8'h00, 6'h00, 6'h3f, 8'h01},
			{3'h1, 8'h01, 6'h01, 6'h00, 8'h15},
			{3'h2, 8'h80, 6'h08, 6'h08, 8'h2d},
			{3'h3, 8'h00, 6'h3f, 6'h00, 8'h31},
			{3'h4, 8'h00, 6'h20, 6'h20, 8'h49},
			{3'h5, 8'h10, 6'h00, 6'h3f, 8'h55},
			{3'h6, 8'h00, 6'h01, 6'h3e, 8'h61},
			{3'h7, 8'h00, 6'h3f, 6'h3f, 8'h79}};
		repeat (2) @(posedge clk);
		chk(main_status, 8'h05);
		resetn <= 1'b1;
		rd_chk(csfp_pkg::ADDR_COMMAND_CONTROL, 8'h80);
		rd_chk(csfp_pkg::ADDR_QUEUE_FILL_COUNT, 8'h00);
		@(posedge clk);
		host_port_detect_pending <= 1'b0;
		rd_chk(csfp_pkg::ADDR_COMMAND_CONTROL, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{modem_phase, error_flag_set, receiver_request,
				request_enable_mask} <= rows[i][30:8];
			rd_chk(csfp_pkg::ADDR_MAIN_STATUS,
				rows[i][7:0]);
			chk(main_status, rows[i][7:0]);
		end
		csfp_host_model_i.reg_wr(csfp_pkg::ADDR_MAIN_STATUS, 8'hff);
		rd_chk(csfp_pkg::ADDR_MAIN_STATUS, 8'h79);
		csfp_host_model_i.reg_wr(csfp_pkg::ADDR_QUEUE_FILL_COUNT, 8'h11);
		rd_chk(csfp_pkg::ADDR_QUEUE_FILL_COUNT, 8'h00);
		{modem_phase, error_flag_set, receiver_request} <= '0;
		$display("status table test done");
		csfp_host_model_i.reg_wr(csfp_pkg::ADDR_COMMAND_CONTROL, 8'h0c);
		#1;
		chk({cmd_start, 1'b0, cmd_code}, 8'h8c);
		rd_chk(csfp_pkg::ADDR_COMMAND_CONTROL, 8'h0c);
		@(posedge clk);
		cmd_done <= 1'b1;
		@(posedge clk);
		cmd_done <= 1'b0;
		rd_chk(csfp_pkg::ADDR_COMMAND_CONTROL, 8'h00);
		$display("command test done");
		for (int i = 0; i < 64; i++) begin
			csfp_host_model_i.reg_wr(csfp_pkg::ADDR_QUEUE_DATA_PORT,
				8'(i * 3 + 1));
			rd_chk(csfp_pkg::ADDR_QUEUE_FILL_COUNT, 8'(i + 1));
			rd_chk(csfp_pkg::ADDR_MAIN_STATUS,
				{6'h00, 1'(63 - i <= 4), 1'(i + 1 <= 4)});
		end
		csfp_host_model_i.reg_wr(csfp_pkg::ADDR_QUEUE_DATA_PORT, 8'hee);
		rd_chk(csfp_pkg::ADDR_QUEUE_FILL_COUNT, 8'h40);
		for (int i = 0; i < 64; i++) begin
			rd_chk(csfp_pkg::ADDR_QUEUE_DATA_PORT, 8'(i * 3 + 1));
		end
		rd_chk(csfp_pkg::ADDR_QUEUE_DATA_PORT, 8'h00);
		rd_chk(csfp_pkg::ADDR_QUEUE_FILL_COUNT, 8'h00);
		$display("queue fill and drain test done");
		@(posedge clk);
		core_req <= '{1'b1, 1'b0, 8'h55};
		@(posedge clk);
		core_req <= '{1'b0, 1'b0, 8'haa};
		rd_chk(csfp_pkg::ADDR_QUEUE_DATA_PORT, 8'h55);
		csfp_host_model_i.reg_wr(csfp_pkg::ADDR_QUEUE_DATA_PORT, 8'h3c);
		@(posedge clk);
		core_req <= '{1'b0, 1'b1, 8'h55};
		@(posedge clk);
		core_req <= '0;
		#1;
		chk(core_rdata, 8'h3c);
		chk({7'h00, core_rvalid}, 8'h01);
		rd_chk(csfp_pkg::ADDR_QUEUE_FILL_COUNT, 8'h00);
		$display("data path test done");
		conclude();
	end
endmodule : test_command_status_fifo_page
